// *** hw/dio_cnt.v ***
// Purpose: one 32-bit counter: pulse, up/down or quadrature decode
// Assumes: phase and reset lines synchronous to clk_i
// Notes:   value wraps by plain 32-bit two's complement arithmetic
`timescale 1ns/10ps
`include "dio_defs.vh"

module dio_cnt #(
    parameter WIDTH = 32
) (
    // clock, reset, enable
    input  wire             clk_i,
    input  wire             rst_i,
    input  wire             ce_i,
    // configuration
    input  wire [1:0]       mode_i,
    input  wire             ren_i,
    input  wire             sample_i,
    // selected lines
    input  wire             a_i,
    input  wire             b_i,
    input  wire             r_i,
    // results
    output reg  [WIDTH-1:0] cnt_o,
    output reg  [WIDTH-1:0] cap_o
);

    reg             a_ff;
    reg             b_ff;
    reg             up;
    reg             dn;
    reg [WIDTH-1:0] nxt_cnt;

    // step decision from the previous and current phase levels
    always @* begin
        up = 1'b0;
        dn = 1'b0;
        case (mode_i)
            `DIO_MODE_PULSE: begin
                up = a_i & ~a_ff;
            end
            `DIO_MODE_UPDN: begin
                // b high counts down on each rising a
                up = a_i & ~a_ff & ~b_i;
                dn = a_i & ~a_ff & b_i;
            end
            `DIO_MODE_QUAD: begin
                // one phase changed: direction from a versus old b
                if ((a_i ^ a_ff) ^ (b_i ^ b_ff)) begin
                    up = a_i ^ b_ff;
                    dn = ~(a_i ^ b_ff);
                end
            end
            default: begin
                up = 1'b0;
            end
        endcase
    end

    // next count; the external reset beats any step
    always @* begin
        nxt_cnt = cnt_o;
        if (ren_i && r_i)
            nxt_cnt = {WIDTH{1'b0}};
        else if (up)
            nxt_cnt = cnt_o + {{(WIDTH-1){1'b0}}, 1'b1};
        else if (dn)
            nxt_cnt = cnt_o - {{(WIDTH-1){1'b0}}, 1'b1};
    end

    // state and capture on the common sample strobe
    always @(posedge clk_i) begin
        if (rst_i) begin
            a_ff  <= 1'b0;
            b_ff  <= 1'b0;
            cnt_o <= {WIDTH{1'b0}};
            cap_o <= {WIDTH{1'b0}};
        end else if (ce_i) begin
            a_ff  <= a_i;
            b_ff  <= b_i;
            cnt_o <= nxt_cnt;
            if (sample_i)
                cap_o <= cnt_o;
        end
    end

endmodule

// *** hw/dio_defs.vh ***
// Purpose: register map, field positions, reset values and modes of the
//          digital port and counter block
// Assumes: 32-bit classic wishbone, byte addresses, word aligned
// Notes:   definitions only
`ifndef DIO_DEFS_VH
`define DIO_DEFS_VH

// register byte offsets
`define DIO_DIR_OFS       8'h00
`define DIO_OUT_OFS       8'h04
`define DIO_SNAP_OFS      8'h08
`define DIO_LIVE_OFS      8'h0c
`define DIO_CNT_BASE      8'h10
`define DIO_CNT_STRIDE    8'h10
`define DIO_CNT_CFG_OFS   4'h0
`define DIO_CNT_VAL_OFS   4'h4
`define DIO_CNT_CAP_OFS   4'h8

// reset values: port a groups input, port b groups output
`define DIO_DIR_RST       4'hc
`define DIO_OUT_RST       32'h0000_0000
`define DIO_CFG_RST       32'h0000_0000

// counter configuration fields
`define DIO_CFG_MODE_LSB  0
`define DIO_CFG_MODE_MSB  1
`define DIO_CFG_REN_BIT   2
`define DIO_CFG_A_LSB     8
`define DIO_CFG_A_MSB     12
`define DIO_CFG_B_LSB     16
`define DIO_CFG_B_MSB     20
`define DIO_CFG_R_LSB     24
`define DIO_CFG_R_MSB     28
`define DIO_CFG_MASK      32'h1f1f_1f07

// counter modes
`define DIO_MODE_OFF      2'h0
`define DIO_MODE_PULSE    2'h1
`define DIO_MODE_UPDN     2'h2
`define DIO_MODE_QUAD     2'h3

`endif

// *** hw/dio_top.v ***
// Purpose: two 16-line digital ports and three counters behind wishbone
// Assumes: pin inputs and sample strobe synchronous to clk_i
// Notes:   line index 0..15 is port a, 16..31 is port b
//
// How it works
// - two 16-line ports, direction chosen per group of eight lines
// - after reset port a lines are inputs, port b lines are outputs
// - inputs and counters are captured on the analog sample strobe
// - three 32-bit counters, each input picked from any of 32 lines
// - pulse mode adds one per rising edge of phase a
// - counting past the range end wraps to the range start
// - an enabled external reset line clears the counter on the next clock edge with ce_i high, ahead of any step
// - quadrature mode counts up or down from the a/b phase order
`timescale 1ns/10ps
`include "dio_defs.vh"

module dio_top #(
    parameter NCNT  = 3,
    parameter CW    = 32,
    parameter AW    = 8
) (
    // clock, reset, enable
    input  wire          clk_i,
    input  wire          rst_i,
    input  wire          ce_i,
    // wishbone slave
    input  wire          wb_cyc_i,
    input  wire          wb_stb_i,
    input  wire          wb_we_i,
    input  wire [AW-1:0] wb_adr_i,
    input  wire [3:0]    wb_sel_i,
    input  wire [31:0]   wb_dat_i,
    output reg  [31:0]   wb_dat_o,
    output reg           wb_ack_o,
    // sample strobe shared with the analog front end
    input  wire          sample_i,
    // digital lines
    input  wire [31:0]   dio_i,
    output reg  [31:0]   dio_o,
    output reg  [31:0]   dio_oe_n_o
);

    ////////////////////////////////////////////////////////////////////////
    // bus decode

    wire        req;
    wire        wr;
    wire [7:0]  adr;

    reg  [3:0]  dir_ff;
    reg  [31:0] out_ff;
    reg  [31:0] snap_ff;
    reg  [31:0] nxt_dat;

    // one request per access; ack drops in the cycle after it rose
    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr  = req & wb_we_i;
    assign adr = {wb_adr_i[7:2], 2'b00};

    // byte lanes merge the written word into the old one
    function [31:0] merge;
        input [31:0] old;
        input [31:0] din;
        input [3:0]  sel;
        integer      k;
        begin
            merge = old;
            for (k = 0; k < 4; k = k + 1) begin
                if (sel[k])
                    merge[k*8 +: 8] = din[k*8 +: 8];
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // ports: direction, output data, input snapshot

    // four groups of eight lines, bit set means the group drives
    always @(posedge clk_i) begin
        if (rst_i) begin
            dir_ff <= `DIO_DIR_RST;
            out_ff <= `DIO_OUT_RST;
        end else if (ce_i) begin
            if (wr && adr == `DIO_DIR_OFS && wb_sel_i[0])
                dir_ff <= wb_dat_i[3:0];
            if (wr && adr == `DIO_OUT_OFS)
                out_ff <= merge(out_ff, wb_dat_i, wb_sel_i);
        end
    end

    // pins come from flops; enables follow direction one cycle later
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : grp
            always @(posedge clk_i) begin
                if (rst_i) begin
                    dio_o[g*8 +: 8]      <= 8'h00;
                    dio_oe_n_o[g*8 +: 8] <= (g < 2) ? 8'hff : 8'h00;
                end else if (ce_i) begin
                    dio_o[g*8 +: 8]      <= out_ff[g*8 +: 8];
                    // input groups release the pins to outside sources
                    dio_oe_n_o[g*8 +: 8] <= {8{~dir_ff[g]}};
                end
            end
        end
    endgenerate

    // snapshot taken with the analog conversion, so data lines up
    always @(posedge clk_i) begin
        if (rst_i)
            snap_ff <= 32'h0000_0000;
        else if (ce_i && sample_i)
            snap_ff <= dio_i;
    end

    ////////////////////////////////////////////////////////////////////////
    // counters

    reg  [31:0]   cfg_ff [0:NCNT-1];
    wire [CW-1:0] cnt_val [0:NCNT-1];
    wire [CW-1:0] cnt_cap [0:NCNT-1];

    genvar c;
    generate
        for (c = 0; c < NCNT; c = c + 1) begin : chan
            wire [31:0] base_w;
            wire [7:0]  base;
            wire [4:0]  a_sel;
            wire [4:0]  b_sel;
            wire [4:0]  r_sel;

            // genvar math is 32 bits wide; only the low byte decodes
            assign base_w = `DIO_CNT_BASE + c * `DIO_CNT_STRIDE;
            assign base   = base_w[7:0];
            assign a_sel = cfg_ff[c][`DIO_CFG_A_MSB:`DIO_CFG_A_LSB];
            assign b_sel = cfg_ff[c][`DIO_CFG_B_MSB:`DIO_CFG_B_LSB];
            assign r_sel = cfg_ff[c][`DIO_CFG_R_MSB:`DIO_CFG_R_LSB];

            // configuration: mode, reset enable and three line selects
            always @(posedge clk_i) begin
                if (rst_i)
                    cfg_ff[c] <= `DIO_CFG_RST;
                else if (ce_i && wr &&
                         adr == base + {4'h0, `DIO_CNT_CFG_OFS})
                    cfg_ff[c] <= merge(cfg_ff[c], wb_dat_i, wb_sel_i)
                                 & `DIO_CFG_MASK;
            end

            // any of the 32 pins may feed any counter input
            dio_cnt #(
                .WIDTH    (CW)
            ) u_cnt (
                .clk_i    (clk_i),
                .rst_i    (rst_i),
                .ce_i     (ce_i),
                .mode_i   (cfg_ff[c][`DIO_CFG_MODE_MSB:`DIO_CFG_MODE_LSB]),
                .ren_i    (cfg_ff[c][`DIO_CFG_REN_BIT]),
                .sample_i (sample_i),
                .a_i      (dio_i[a_sel]),
                .b_i      (dio_i[b_sel]),
                .r_i      (dio_i[r_sel]),
                .cnt_o    (cnt_val[c]),
                .cap_o    (cnt_cap[c])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // read mux; unmapped words read zero and are still acked

    integer i;
    always @* begin
        nxt_dat = 32'h0000_0000;
        case (adr)
            `DIO_DIR_OFS:  nxt_dat = {28'h0000000, dir_ff};
            `DIO_OUT_OFS:  nxt_dat = out_ff;
            `DIO_SNAP_OFS: nxt_dat = snap_ff;
            `DIO_LIVE_OFS: nxt_dat = dio_i;
            default: begin
                for (i = 0; i < NCNT; i = i + 1) begin
                    if (adr == `DIO_CNT_BASE + i[7:0] * `DIO_CNT_STRIDE
                               + {4'h0, `DIO_CNT_CFG_OFS})
                        nxt_dat = cfg_ff[i];
                    if (adr == `DIO_CNT_BASE + i[7:0] * `DIO_CNT_STRIDE
                               + {4'h0, `DIO_CNT_VAL_OFS})
                        nxt_dat = cnt_val[i];
                    if (adr == `DIO_CNT_BASE + i[7:0] * `DIO_CNT_STRIDE
                               + {4'h0, `DIO_CNT_CAP_OFS})
                        nxt_dat = cnt_cap[i];
                end
            end
        endcase
    end

    // answer one cycle after the request is seen
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else if (ce_i) begin
            wb_ack_o <= req;
            if (req && !wb_we_i)
                wb_dat_o <= nxt_dat;
        end
    end

endmodule

// *** sim/dio_ext.sv ***
// Purpose: outside signal sources and encoders on the digital lines
// Assumes: tasks are called just after a rising clock edge
// Notes:   source levels start low, so input lines read low until a task drives them
`timescale 1ns/10ps
module dio_ext (
    // clock and device pins
    input  wire        clk_i,
    input  wire [31:0] dio_o,
    input  wire [31:0] dio_oe_n_o,
    output wire [31:0] dio_i
);
    reg [31:0] src_ff = 32'h0;
    reg [1:0]  qst_ff = 2'h0;
    // sources stay off lines the device drives, avoiding contention
    assign dio_i = (~dio_oe_n_o & dio_o) | (dio_oe_n_o & src_ff);
    // whole word of source levels
    task word(input [31:0] v);
        src_ff <= v;
        @(posedge clk_i);
    endtask
    // one line level, held for h cycles
    task put(input integer i, input reg v, input integer h);
        src_ff[i] <= v;
        repeat (h) @(posedge clk_i);
    endtask
    task pulses(input integer i, input integer n, input integer h);
        repeat (n) begin
            put(i, 1'b1, h);
            put(i, 1'b0, h);
        end
    endtask
    // gray steps, a leads b when counting up; one phase moves per step
    task quad(input integer ia, input integer ib, input integer n,
              input reg up, input integer h);
        repeat (n) begin
            qst_ff = up ? qst_ff + 2'h1 : qst_ff - 2'h1;
            src_ff[ia] <= (qst_ff == 2'h1) || (qst_ff == 2'h2);
            src_ff[ib] <= qst_ff[1];
            repeat (h) @(posedge clk_i);
        end
    endtask
endmodule

// *** sim/dio_top_chk.sv ***
// Purpose: bus, pin and snapshot checks on the dio_top ports
// Assumes: ce_i high while the bus is in use
// Notes:   counter values are judged by the bench, not here
`timescale 1ns/10ps
module dio_chk #(
    parameter AW = 8
) (
    // clock, reset, enable
    input wire          clk_i,
    input wire          rst_i,
    input wire          ce_i,
    // wishbone
    input wire          wb_cyc_i,
    input wire          wb_stb_i,
    input wire          wb_we_i,
    input wire [AW-1:0] wb_adr_i,
    input wire [3:0]    wb_sel_i,
    input wire [31:0]   wb_dat_i,
    input wire [31:0]   wb_dat_o,
    input wire          wb_ack_o,
    // strobe and lines
    input wire          sample_i,
    input wire [31:0]   dio_i,
    input wire [31:0]   dio_o,
    input wire [31:0]   dio_oe_n_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire       take = wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
    wire       rd   = take && !wb_we_i;
    reg [31:0] snap_ff;
    // own snapshot copy; reads coinciding with a strobe are skipped
    always @(posedge clk_i) begin
        if (rst_i)
            snap_ff <= 32'h0;
        else if (ce_i && sample_i)
            snap_ff <= dio_i;
    end
    // one direction bit spread over its eight lines
    function automatic [31:0] fan(input [3:0] d);
        fan = {{8{d[3]}}, {8{d[2]}}, {8{d[1]}}, {8{d[0]}}};
    endfunction
    ////////////////////////////////////////////////////////////
    sequence s_ack; wb_ack_o ##1 !wb_ack_o; endsequence
    property p_ack; take |=> s_ack; endproperty
    a_ack: assert property (p_ack) else $error("ack not one pulse");
    property p_rst; $fell(rst_i) |-> dio_oe_n_o == 32'h0000ffff; endproperty
    a_rst: assert property (p_rst) else $error("bad reset dir");
    property p_grp;
        dio_oe_n_o == fan({dio_oe_n_o[24], dio_oe_n_o[16],
                           dio_oe_n_o[8], dio_oe_n_o[0]});
    endproperty
    a_grp: assert property (p_grp) else $error("split group");
    property p_dir; take && wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[0]
        |-> ##2 dio_oe_n_o == ~fan($past(wb_dat_i[3:0], 2)); endproperty
    a_dir: assert property (p_dir) else $error("dir not applied");
    property p_out; take && wb_we_i && wb_adr_i == 8'h04 && wb_sel_i == 4'hf
        |-> ##2 dio_o == $past(wb_dat_i, 2); endproperty
    a_out: assert property (p_out) else $error("out not applied");
    property p_live; rd && wb_adr_i == 8'h0c |=> wb_dat_o == $past(dio_i);
    endproperty
    a_live: assert property (p_live) else $error("live wrong");
    property p_snap; rd && wb_adr_i == 8'h08 && !sample_i
        |=> wb_dat_o == $past(snap_ff); endproperty
    a_snap: assert property (p_snap) else $error("snap wrong");
    property p_unm; rd && wb_adr_i[7:6] != 2'h0 |=> wb_dat_o == 32'h0;
    endproperty
    a_unm: assert property (p_unm) else $error("unmapped read not 0");
endmodule
bind dio_top dio_chk #(.AW(AW)) dio_chk_inst (.*);

// *** sim/tb.sv ***
// Purpose: self-checking bench for dio_top
// Assumes: ce_i high except during the freeze step of t_rline; lines driven by dio_ext
// Notes:   wrap at the range end is out of reach without a preload
`timescale 1ns/10ps
module tb;
    reg         clk_i = 1'b0;
    reg         rst_i = 1'b1;
    reg         ce_i = 1'b1;
    reg         wb_cyc_i = 1'b0;
    reg         wb_stb_i = 1'b0;
    reg         wb_we_i = 1'b0;
    reg  [7:0]  wb_adr_i = 8'h00;
    reg  [3:0]  wb_sel_i = 4'h0;
    reg  [31:0] wb_dat_i = 32'h0;
    reg         sample_i = 1'b0;
    wire [31:0] wb_dat_o, dio_i, dio_o, dio_oe_n_o;
    wire        wb_ack_o;
    reg  [31:0] rd_ff;
    integer     err_count = 0;
    integer     comparisons = 0;
    integer     cyc_cnt = 0;
`define CHK(n, e, g) begin comparisons = comparisons + 1; \
    if ((g) !== (e)) begin err_count = err_count + 1; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
    always #2 clk_i = ~clk_i;
    dio_top dio_top_inst (.*);
    dio_ext dio_ext_inst (.*);
    task finish_test;
        $display("checks %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // hang guard, far above the few hundred cycles needed
    always @(posedge clk_i) begin
        cyc_cnt = cyc_cnt + 1;
        if (cyc_cnt == 5000) begin
            err_count = err_count + 1;
            finish_test;
        end
    end
    ////////////////////////////////////////////////////////////
    task wb(input reg w, input [7:0] a, input [31:0] d, input [3:0] s);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) @(posedge clk_i);
        rd_ff = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task rc(input string n, input [7:0] a, input [31:0] e);
        wb(1'b0, a, 32'h0, 4'h0);
        `CHK(n, e, rd_ff)
    endtask
    task strobe;
        @(posedge clk_i);
        sample_i <= 1'b1;
        @(posedge clk_i);
        sample_i <= 1'b0;
    endtask
    task t_reset;
        `CHK("oe_n", 32'h0000ffff, dio_oe_n_o)
        `CHK("out", 32'h0, dio_o)
        rc("dir", 8'h00, 32'h0000000c);
        rc("unmapped", 8'h40, 32'h0);
    endtask
    task t_dir;
        wb(1'b1, 8'h00, 32'h3, 4'h1);
        wb(1'b1, 8'h04, 32'h1234_5678, 4'hf);
        wb(1'b1, 8'h04, 32'hffff_ffff, 4'h2);
        @(posedge clk_i);
        `CHK("oe_n", 32'hffff_0000, dio_oe_n_o)
        `CHK("out", 32'h1234_ff78, dio_o)
        rc("live", 8'h0c, 32'h0000_ff78);
        wb(1'b1, 8'h00, 32'hc, 4'h1);
        wb(1'b1, 8'h04, 32'h0, 4'hf);
    endtask
    task t_sample;
        dio_ext_inst.word(32'h0000_a5c3);
        strobe;
        dio_ext_inst.word(32'h0000_0f0f);
        rc("snap", 8'h08, 32'h0000_a5c3);
        dio_ext_inst.word(32'h0);
    endtask
    task t_pulse;
        wb(1'b1, 8'h10, 32'h0000_0001, 4'hf);
        dio_ext_inst.pulses(0, 5, 8);
        strobe;
        dio_ext_inst.pulses(0, 3, 1);
        rc("val0", 8'h14, 32'd8);
        rc("cap0", 8'h18, 32'd5);
    endtask
    task t_rline;
        wb(1'b1, 8'h10, 32'h0300_0005, 4'hf);
        dio_ext_inst.put(3, 1'b1, 1);
        dio_ext_inst.pulses(0, 4, 1);
        rc("val0 held", 8'h14, 32'h0);
        dio_ext_inst.put(3, 1'b0, 1);
        dio_ext_inst.pulses(0, 2, 2);
        rc("val0 run", 8'h14, 32'd2);
        // enable low: pulses on line 0 must leave the count alone
        ce_i <= 1'b0;
        dio_ext_inst.pulses(0, 3, 1);
        ce_i <= 1'b1;
        rc("val0 frozen", 8'h14, 32'd2);
    endtask
    task t_updn;
        wb(1'b1, 8'h20, 32'h0005_0402, 4'hf);
        dio_ext_inst.pulses(4, 3, 2);
        dio_ext_inst.put(5, 1'b1, 2);
        dio_ext_inst.pulses(4, 5, 2);
        rc("val1", 8'h24, 32'hffff_fffe);
    endtask
    task t_quad;
        wb(1'b1, 8'h00, 32'h8, 4'h1);
        wb(1'b1, 8'h30, 32'h0011_1003, 4'hf);
        dio_ext_inst.quad(16, 17, 6, 1'b1, 2);
        rc("val2 up", 8'h34, 32'd6);
        dio_ext_inst.quad(16, 17, 10, 1'b0, 1);
        rc("val2 down", 8'h34, 32'hffff_fffc);
    endtask
    // main sequence
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset;
        t_dir;
        t_sample;
        t_pulse;
        t_rline;
        t_updn;
        t_quad;
        finish_test;
    end
endmodule
